// ---- swr_regs.svh ----
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH

// Avalon byte offsets
`define SWR_ADDR_CTRL       5'h00
`define SWR_ADDR_STATUS     5'h04
`define SWR_ADDR_IRQ_STAT   5'h08
`define SWR_ADDR_IRQ_MASK   5'h0C
`define SWR_ADDR_WDT_COUNT  5'h10

// Control register fields
`define SWR_CTRL_WDT_EN     0
`define SWR_CTRL_PINWK_EN   1
`define SWR_CTRL_CMPWK_EN   2
`define SWR_CTRL_RSTPIN_EN  3
`define SWR_CTRL_PSA        4
`define SWR_CTRL_PS_LSB     5
`define SWR_CTRL_RESET      8'h1F

// Status register fields
`define SWR_STAT_SLEEP      0
`define SWR_STAT_PD_N       3
`define SWR_STAT_TO_N       4
`define SWR_STAT_CMPWK      6
`define SWR_STAT_PINWK      7

// Interrupt status / mask fields
`define SWR_IRQ_WDT         0
`define SWR_IRQ_WAKE        1
`define SWR_IRQ_SLEEP       2
`define SWR_IRQ_MASK_RESET  3'h0

// Timing
`define SWR_CLK_PERIOD_NS   5
`define SWR_WDT_PERIOD_NS   18000000
`define SWR_DRT_POR_NS      1125000
`define SWR_DRT_SUB_NS      10000
`define SWR_NS_TO_CYC(ns)   (((ns) + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)
`define SWR_WDT_CYC         `SWR_NS_TO_CYC(`SWR_WDT_PERIOD_NS)
`define SWR_DRT_POR_CYC     `SWR_NS_TO_CYC(`SWR_DRT_POR_NS)
`define SWR_DRT_SUB_CYC     `SWR_NS_TO_CYC(`SWR_DRT_SUB_NS)

`endif

// ---- swr_pkg.sv ----
package swr_pkg;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_HOLD  = 2'b10
  } swr_state_t;

  typedef enum logic [1:0] {
    CS_POR  = 2'b00,
    CS_PIN  = 2'b01,
    CS_WDT  = 2'b10,
    CS_WAKE = 2'b11
  } swr_cause_t;

endpackage

// ---- swr_sleep_wake.sv ----
`timescale 1ns/1ps
`include "swr_regs.svh"

module swr_sleep_wake #(
  parameter int unsigned WDT_CYCLES     = `SWR_WDT_CYC,
  parameter int unsigned DRT_POR_CYCLES = `SWR_DRT_POR_CYC
) (
  input  logic        ref_clk_i,
  input  logic        rst_i,
  input  logic [4:0]  avs_address_i,
  input  logic        avs_read_i,
  input  logic        avs_write_i,
  input  logic [31:0] avs_writedata_i,
  input  logic [3:0]  avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic        avs_waitrequest_o,
  output logic        irq_o,
  input  logic        sleep_instr_i,
  input  logic        clear_watchdog_i,
  input  logic        port_access_i,
  input  logic        comparator_ctrl_read_i,
  input  logic        external_reset_pin_n_i,
  output logic        external_reset_pin_n_o,
  output logic        external_reset_pin_n_oe_o,
  input  logic        wake_pin_zero_i,
  input  logic        wake_pin_one_i,
  input  logic        wake_pin_three_i,
  input  logic        wake_pin_four_i,
  input  logic        comparator_one_output_i,
  input  logic        comparator_two_output_i,
  input  logic [3:0]  port_out_i,
  input  logic [3:0]  port_oe_i,
  output logic [3:0]  port_out_o,
  output logic [3:0]  port_oe_o,
  output logic        core_reset_o,
  output logic        osc_drive_en_o,
  output logic        sleeping_o,
  output logic        timeout_flag_n_o,
  output logic        powerdown_flag_n_o,
  output logic        pin_wake_flag_o,
  output logic        comparator_wake_flag_o
);

  function automatic logic [6:0] presc_limit(input logic [2:0] ps);
    presc_limit = 7'((8'h01 << ps) - 8'h01);
  endfunction

  swr_pkg::swr_state_t state;
  swr_pkg::swr_cause_t cause;
  logic [7:0]          ctrl;
  logic [2:0]          irq_stat;
  logic [2:0]          irq_mask;
  logic [31:0]         wdt_base;
  logic [6:0]          presc;
  logic [31:0]         drt_cnt;
  logic [3:0]          pin_latch;
  logic [1:0]          cmp_latch;
  logic                timeout_flag_n;
  logic                powerdown_flag_n;
  logic                pin_wake_flag;
  logic                comparator_wake_flag;

  logic       wdt_en;
  logic       psa;
  logic [3:0] wake_pins;
  logic [1:0] cmp_now;
  logic       ext_rst;
  logic       base_tick;
  logic       wdt_timeout;
  logic       pin_change;
  logic       cmp_change;
  logic       run_reset;
  logic       sleep_go;
  logic       wake_any;
  logic       wdt_clear;
  logic       bus_write;
  logic [2:0] irq_event;
  logic [2:0] irq_clear;

  assign wdt_en    = ctrl[`SWR_CTRL_WDT_EN];
  assign psa       = ctrl[`SWR_CTRL_PSA];
  assign wake_pins = {wake_pin_four_i, wake_pin_three_i, wake_pin_one_i, wake_pin_zero_i};
  assign cmp_now   = {comparator_two_output_i, comparator_one_output_i};
  assign ext_rst   = ctrl[`SWR_CTRL_RSTPIN_EN] && !external_reset_pin_n_i;
  assign base_tick = wdt_en && (wdt_base == 32'(WDT_CYCLES - 1));
  assign wdt_timeout = base_tick
                       && (!psa || presc == presc_limit(ctrl[`SWR_CTRL_PS_LSB +: 3]));
  assign pin_change = ctrl[`SWR_CTRL_PINWK_EN] && (wake_pins != pin_latch);
  assign cmp_change = ctrl[`SWR_CTRL_CMPWK_EN] && (cmp_now != cmp_latch);
  assign run_reset  = (state == swr_pkg::ST_RUN) && (ext_rst || wdt_timeout);
  // A reset request in the same cycle as the sleep instruction wins
  assign sleep_go   = (state == swr_pkg::ST_RUN) && sleep_instr_i && !run_reset;
  assign wake_any   = (state == swr_pkg::ST_SLEEP)
                      && (ext_rst || wdt_timeout || pin_change || cmp_change);
  assign wdt_clear  = sleep_go || wake_any || run_reset || clear_watchdog_i
                      || (state == swr_pkg::ST_HOLD);
  assign bus_write  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign irq_event  = {sleep_go, wake_any, wdt_timeout && (state != swr_pkg::ST_HOLD)};
  assign irq_clear  = (bus_write && avs_address_i == `SWR_ADDR_IRQ_STAT)
                      ? avs_writedata_i[2:0] : 3'h0;

  // Sequencer: run, sleep, and reset hold timed by the start-up delay
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state   <= swr_pkg::ST_HOLD;
      cause   <= swr_pkg::CS_POR;
      drt_cnt <= 32'(DRT_POR_CYCLES - 1);
    end else begin
      case (state)
        swr_pkg::ST_RUN: begin
          if (run_reset) begin
            state   <= swr_pkg::ST_HOLD;
            cause   <= ext_rst ? swr_pkg::CS_PIN : swr_pkg::CS_WDT;
            drt_cnt <= 32'(`SWR_DRT_SUB_CYC - 1);
          end else if (sleep_go) begin
            state <= swr_pkg::ST_SLEEP;
          end
        end
        swr_pkg::ST_SLEEP: begin
          if (wake_any) begin
            state   <= swr_pkg::ST_HOLD;
            cause   <= ext_rst ? swr_pkg::CS_PIN
                     : wdt_timeout ? swr_pkg::CS_WDT : swr_pkg::CS_WAKE;
            drt_cnt <= 32'(`SWR_DRT_SUB_CYC - 1);
          end
        end
        swr_pkg::ST_HOLD: begin
          // The delay only counts while the reset pin is released
          if (!ext_rst) begin
            if (drt_cnt == 32'h0000_0000) begin
              state <= swr_pkg::ST_RUN;
            end else begin
              drt_cnt <= drt_cnt - 32'h0000_0001;
            end
          end
        end
        default: begin
          state <= swr_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // Reset-cause flags
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      timeout_flag_n       <= 1'b1;
      powerdown_flag_n     <= 1'b1;
      pin_wake_flag        <= 1'b0;
      comparator_wake_flag <= 1'b0;
    end else if (run_reset) begin
      pin_wake_flag        <= 1'b0;
      comparator_wake_flag <= 1'b0;
      if (!ext_rst) begin
        timeout_flag_n <= 1'b0;
      end
    end else if (sleep_go) begin
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b0;
    end else if (wake_any) begin
      powerdown_flag_n <= 1'b0;
      if (ext_rst) begin
        timeout_flag_n       <= 1'b1;
        pin_wake_flag        <= 1'b0;
        comparator_wake_flag <= 1'b0;
      end else if (wdt_timeout) begin
        timeout_flag_n       <= 1'b0;
        pin_wake_flag        <= 1'b0;
        comparator_wake_flag <= 1'b0;
      end else if (pin_change) begin
        timeout_flag_n       <= 1'b1;
        pin_wake_flag        <= 1'b1;
        comparator_wake_flag <= 1'b0;
      end else begin
        timeout_flag_n       <= 1'b1;
        pin_wake_flag        <= 1'b0;
        comparator_wake_flag <= 1'b1;
      end
    end
  end

  // Reference values for change detection; without a fresh read before sleep
  // a stale mismatch wakes the device at once
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_latch <= 4'h0;
    end else if (port_access_i) begin
      pin_latch <= wake_pins;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmp_latch <= 2'h0;
    end else if (comparator_ctrl_read_i) begin
      cmp_latch <= cmp_now;
    end
  end

  // Watchdog keeps counting in sleep; the clear or sleep instruction, a wake, a reset or the reset hold clears it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || wdt_clear) begin
      wdt_base <= 32'h0000_0000;
      presc    <= 7'h00;
    end else if (wdt_en) begin
      if (base_tick) begin
        wdt_base <= 32'h0000_0000;
        if (psa) begin
          presc <= presc + 7'h01;
        end
      end else begin
        wdt_base <= wdt_base + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      osc_drive_en_o <= 1'b1;
    end else if (sleep_go) begin
      osc_drive_en_o <= 1'b0;
    end else if (wake_any) begin
      osc_drive_en_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b1;
      sleeping_o   <= 1'b0;
    end else begin
      core_reset_o <= (state == swr_pkg::ST_HOLD && (ext_rst || drt_cnt != 32'h0000_0000))
                      || run_reset || wake_any;
      sleeping_o   <= sleep_go || (state == swr_pkg::ST_SLEEP && !wake_any);
    end
  end

  // Port drivers freeze in sleep and float while the core is held in reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      port_out_o <= 4'h0;
      port_oe_o  <= 4'h0;
    end else if (state == swr_pkg::ST_HOLD) begin
      port_oe_o <= 4'h0;
    end else if (state != swr_pkg::ST_SLEEP) begin
      port_out_o <= port_out_i;
      port_oe_o  <= port_oe_i;
    end
  end

  // The reset pin is input only; an internal reset is never driven back out
  always_ff @(posedge ref_clk_i) begin
    external_reset_pin_n_o    <= 1'b1;
    external_reset_pin_n_oe_o <= 1'b0;
  end

  always_ff @(posedge ref_clk_i) begin
    timeout_flag_n_o       <= timeout_flag_n;
    powerdown_flag_n_o     <= powerdown_flag_n;
    pin_wake_flag_o        <= pin_wake_flag;
    comparator_wake_flag_o <= comparator_wake_flag;
  end

  // Avalon slave: one wait state, then answer for one cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      if (avs_address_i == `SWR_ADDR_CTRL) begin
        avs_readdata_o <= {24'h00_0000, ctrl};
      end else if (avs_address_i == `SWR_ADDR_STATUS) begin
        avs_readdata_o <= 32'h0000_0000;
        avs_readdata_o[`SWR_STAT_SLEEP] <= state == swr_pkg::ST_SLEEP;
        avs_readdata_o[`SWR_STAT_PD_N]  <= powerdown_flag_n;
        avs_readdata_o[`SWR_STAT_TO_N]  <= timeout_flag_n;
        avs_readdata_o[`SWR_STAT_CMPWK] <= comparator_wake_flag;
        avs_readdata_o[`SWR_STAT_PINWK] <= pin_wake_flag;
      end else if (avs_address_i == `SWR_ADDR_IRQ_STAT) begin
        avs_readdata_o <= {29'h0000_0000, irq_stat};
      end else if (avs_address_i == `SWR_ADDR_IRQ_MASK) begin
        avs_readdata_o <= {29'h0000_0000, irq_mask};
      end else if (avs_address_i == `SWR_ADDR_WDT_COUNT) begin
        avs_readdata_o <= wdt_base;
      end else begin
        avs_readdata_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl <= `SWR_CTRL_RESET;
    end else if (bus_write && avs_address_i == `SWR_ADDR_CTRL) begin
      ctrl <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_mask <= `SWR_IRQ_MASK_RESET;
    end else if (bus_write && avs_address_i == `SWR_ADDR_IRQ_MASK) begin
      irq_mask <= avs_writedata_i[2:0];
    end
  end

  // A new event in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_stat <= 3'h0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clear) | irq_event;
      irq_o    <= |(irq_stat & irq_mask);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence wdt_wake_s;
    state == swr_pkg::ST_SLEEP && wdt_timeout && !ext_rst;
  endsequence

  sequence held_reset_s;
    core_reset_o [*8];
  endsequence

  sleep_entry_a: assert property (
    sleep_go |=> state == swr_pkg::ST_SLEEP && timeout_flag_n && !powerdown_flag_n
                 && wdt_base == 32'h0000_0000 && presc == 7'h00 && !osc_drive_en_o)
    else $error("sleep entry did not set flags or stop oscillator");

  wdt_sleep_flags_a: assert property (
    wdt_wake_s |=> !timeout_flag_n && !powerdown_flag_n && !pin_wake_flag
                   && !comparator_wake_flag)
    else $error("watchdog wake flags wrong");

  wdt_run_flags_a: assert property (
    run_reset && !ext_rst |=> !timeout_flag_n && powerdown_flag_n == $past(powerdown_flag_n)
                              && !pin_wake_flag && !comparator_wake_flag)
    else $error("watchdog run reset flags wrong");

  pin_rst_wake_a: assert property (
    wake_any && ext_rst |=> timeout_flag_n && !powerdown_flag_n && !pin_wake_flag
                            && !comparator_wake_flag)
    else $error("reset pin wake flags wrong");

  power_up_a: assert property (
    $past(rst_i) |-> timeout_flag_n && powerdown_flag_n && !pin_wake_flag
                     && !comparator_wake_flag && core_reset_o)
    else $error("power-up flags wrong");

  pin_wake_flags_a: assert property (
    wake_any && !ext_rst && !wdt_timeout && pin_change |=> pin_wake_flag
      && !comparator_wake_flag && timeout_flag_n && !powerdown_flag_n)
    else $error("pin wake flags wrong");

  cmp_wake_flags_a: assert property (
    wake_any && !ext_rst && !wdt_timeout && !pin_change |=> comparator_wake_flag
      && !pin_wake_flag && timeout_flag_n && !powerdown_flag_n)
    else $error("comparator wake flags wrong");

  sleep_cause_a: assert property (
    state == swr_pkg::ST_SLEEP && $past(state) != swr_pkg::ST_SLEEP
      |-> $past(sleep_instr_i) && $past(state) == swr_pkg::ST_RUN)
    else $error("sleep entered without the sleep instruction");

  port_hold_a: assert property (
    sleeping_o && $past(sleeping_o) && !core_reset_o |-> $stable(port_out_o) && $stable(port_oe_o))
    else $error("port drive changed during sleep");

  pin_not_driven_a: assert property (
    state == swr_pkg::ST_HOLD && cause == swr_pkg::CS_WDT |-> !external_reset_pin_n_oe_o)
    else $error("watchdog reset drove the reset pin");

  stale_pin_wake_a: assert property (
    sleep_go ##1 (pin_change && state == swr_pkg::ST_SLEEP) |=> state == swr_pkg::ST_HOLD)
    else $error("stale pin mismatch did not wake at once");

  wake_clears_wdt_a: assert property (
    wake_any |=> wdt_base == 32'h0000_0000 && presc == 7'h00)
    else $error("watchdog not cleared on wake");

  drt_hold_a: assert property (
    wdt_wake_s |=> held_reset_s)
    else $error("core released before start-up delay");

endmodule // swr_sleep_wake

// ---- swr_core_model.sv ----
`timescale 1ns/1ps

// Core side: kicks the watchdog while running and issues the sleep instruction
module swr_core_model #(
  parameter int unsigned KICK_PERIOD = 16
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic core_reset_i,
  input  wire logic sleeping_i,
  input  wire logic kick_en_i,
  input  wire logic sleep_req_i,
  output logic      clear_watchdog_o,
  output logic      sleep_instr_o
);
  int unsigned kick_cnt;

  // A held or sleeping core executes nothing, so neither kick nor sleep leaves it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || core_reset_i || sleeping_i) begin
      kick_cnt         <= 0;
      clear_watchdog_o <= 1'h0;
      sleep_instr_o    <= 1'h0;
    end else begin
      kick_cnt         <= (kick_cnt == KICK_PERIOD - 1) ? 0 : kick_cnt + 1;
      clear_watchdog_o <= kick_en_i && (kick_cnt == KICK_PERIOD - 1);
      sleep_instr_o    <= sleep_req_i && !sleep_instr_o;
    end
  end
endmodule // swr_core_model

// ---- sleep_wake_reset_cause_bench.sv ----
`timescale 1ns/1ps
`include "swr_regs.svh"

module sleep_wake_reset_cause_bench;
  logic        clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, wt, irq;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic        sleep_req = 1'h0, kick_en = 1'h1, port_acc = 1'h0, cmp_rd = 1'h0;
  logic        pin_drv = 1'h1, c1 = 1'h0, c2 = 1'h0, clr_wdt, sleep_ins;
  logic [3:0]  wp = 4'h0, pout = 4'h0, poe = 4'h0, pout_o, poe_o;
  logic        ext_o, ext_oe, core_rst, osc, slp, to_n, pd_n, pw_f, cw_f;
  wire         rst_pin = (ext_oe && !ext_o) ? 1'h0 : pin_drv;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #2.5 clk = !clk;

  swr_sleep_wake #(.WDT_CYCLES(50), .DRT_POR_CYCLES(20)) u_dut (
    .ref_clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .irq_o(irq),
    .sleep_instr_i(sleep_ins), .clear_watchdog_i(clr_wdt), .port_access_i(port_acc),
    .comparator_ctrl_read_i(cmp_rd), .external_reset_pin_n_i(rst_pin),
    .external_reset_pin_n_o(ext_o), .external_reset_pin_n_oe_o(ext_oe),
    .wake_pin_zero_i(wp[0]), .wake_pin_one_i(wp[1]), .wake_pin_three_i(wp[2]),
    .wake_pin_four_i(wp[3]), .comparator_one_output_i(c1),
    .comparator_two_output_i(c2), .port_out_i(pout), .port_oe_i(poe),
    .port_out_o(pout_o), .port_oe_o(poe_o), .core_reset_o(core_rst),
    .osc_drive_en_o(osc), .sleeping_o(slp), .timeout_flag_n_o(to_n),
    .powerdown_flag_n_o(pd_n), .pin_wake_flag_o(pw_f), .comparator_wake_flag_o(cw_f));

  swr_core_model u_core (
    .ref_clk_i(clk), .rst_i(rst), .core_reset_i(core_rst), .sleeping_i(slp),
    .kick_en_i(kick_en), .sleep_req_i(sleep_req), .clear_watchdog_o(clr_wdt),
    .sleep_instr_o(sleep_ins));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    addr <= a; wr <= w; rd <= !w; wdata <= d;
    do begin
      @(posedge clk);
      i++;
    end while (wt !== 1'h0);
    q = rdata;
    wr <= 1'h0; rd <= 1'h0;
    check(32'(i), 32'h2);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    check(q, exp);
  endtask

  // Bounded wait for the core hold to reach a level
  task automatic wait_cr(input logic v, input int lim);
    int i;
    i = 0;
    while (core_rst !== v && i < lim) begin
      @(posedge clk);
      i++;
    end
    check({31'h0, core_rst}, {31'h0, v});
  endtask

  task automatic chk_flags(input logic t, input logic p, input logic pw, input logic cw);
    check({28'h0, to_n, pd_n, pw_f, cw_f}, {28'h0, t, p, pw, cw});
  endtask

  // Select bits: port access, sleep request, comparator read
  task automatic pulse(input logic [2:0] sel);
    @(posedge clk);
    {port_acc, sleep_req, cmp_rd} <= sel;
    @(posedge clk);
    {port_acc, sleep_req, cmp_rd} <= 3'h0;
  endtask

  task automatic t_por;
    wait_cr(1'h0, 100);
    chk_flags(1'h1, 1'h1, 1'h0, 1'h0);
    rd_chk(`SWR_ADDR_CTRL, 32'h1F);
    rd_chk(`SWR_ADDR_IRQ_MASK, 32'h0);
    rd_chk(5'h14, 32'h0);
    bus(1'h1, `SWR_ADDR_STATUS, 32'hFF);
    rd_chk(`SWR_ADDR_STATUS, 32'h18);
    tick(200);
    check({31'h0, core_rst}, 32'h0);
    chk_flags(1'h1, 1'h1, 1'h0, 1'h0);
    $display("test por complete");
  endtask

  task automatic t_pin;
    bus(1'h1, `SWR_ADDR_CTRL, 32'h02);
    pout <= 4'hA; poe <= 4'h5;
    pulse(3'h4);
    pulse(3'h2);
    tick(3);
    check({30'h0, slp, osc}, 32'h2);
    tick(2);
    chk_flags(1'h1, 1'h0, 1'h0, 1'h0);
    pout <= 4'h3; poe <= 4'hF;
    tick(20);
    check({24'h0, poe_o, pout_o}, 32'h5A);
    wp <= 4'h1;
    wait_cr(1'h1, 5);
    wait_cr(1'h0, 2200);
    chk_flags(1'h1, 1'h0, 1'h1, 1'h0);
    // Pins left unread: the next sleep must end at once
    pulse(3'h2);
    wait_cr(1'h1, 8);
    wait_cr(1'h0, 2200);
    chk_flags(1'h1, 1'h0, 1'h1, 1'h0);
    $display("test pin wake complete");
  endtask

  task automatic t_cmp;
    bus(1'h1, `SWR_ADDR_CTRL, 32'h04);
    pulse(3'h1);
    pulse(3'h2);
    tick(20);
    check({31'h0, slp}, 32'h1);
    c2 <= 1'h1;
    wait_cr(1'h1, 5);
    wait_cr(1'h0, 2200);
    chk_flags(1'h1, 1'h0, 1'h0, 1'h1);
    bus(1'h1, `SWR_ADDR_CTRL, 32'h08);
    @(posedge clk) pin_drv <= 1'h0;
    wait_cr(1'h1, 5);
    tick(5);
    pin_drv <= 1'h0;
    @(posedge clk) pin_drv <= 1'h1;
    wait_cr(1'h0, 2200);
    chk_flags(1'h1, 1'h0, 1'h0, 1'h0);
    $display("test comparator wake complete");
  endtask

  task automatic t_wdt_run;
    bus(1'h1, `SWR_ADDR_CTRL, 32'h01);
    tick(200);
    check({31'h0, core_rst}, 32'h0);
    kick_en <= 1'h0;
    wait_cr(1'h1, 200);
    kick_en <= 1'h1;
    check({30'h0, ext_oe, ext_o}, 32'h1);
    wait_cr(1'h0, 2200);
    chk_flags(1'h0, 1'h0, 1'h0, 1'h0);
    bus(1'h0, `SWR_ADDR_IRQ_STAT, 32'h0);
    check(q, 32'h7);
    check({31'h0, irq}, 32'h0);
    bus(1'h1, `SWR_ADDR_IRQ_MASK, 32'h1);
    tick(3);
    check({31'h0, irq}, 32'h1);
    bus(1'h1, `SWR_ADDR_IRQ_STAT, 32'h1);
    tick(3);
    check({31'h0, irq}, 32'h0);
    bus(1'h0, `SWR_ADDR_IRQ_STAT, 32'h0);
    check(q, 32'h6);
    $display("test watchdog run complete");
  endtask

  task automatic t_wdt_sleep;
    pulse(3'h2);
    wait_cr(1'h1, 200);
    tick(1990);
    check({31'h0, core_rst}, 32'h1);
    wait_cr(1'h0, 100);
    chk_flags(1'h0, 1'h0, 1'h0, 1'h0);
    bus(1'h0, `SWR_ADDR_WDT_COUNT, 32'h0);
    check({31'h0, q < 32'h20}, 32'h1);
    bus(1'h1, `SWR_ADDR_CTRL, 32'h08);
    pulse(3'h2);
    tick(3);
    @(posedge clk) pin_drv <= 1'h0;
    wait_cr(1'h1, 5);
    tick(5);
    pin_drv <= 1'h1;
    wait_cr(1'h0, 2200);
    chk_flags(1'h1, 1'h0, 1'h0, 1'h0);
    $display("test watchdog sleep and reset pin complete");
  endtask

  // Ratio 1 doubles the span: no reset yet where a bare watchdog would have fired
  task automatic t_presc;
    bus(1'h1, `SWR_ADDR_CTRL, 32'h31);
    kick_en <= 1'h0;
    tick(70);
    check({31'h0, core_rst}, 32'h0);
    wait_cr(1'h1, 50);
    kick_en <= 1'h1;
    wait_cr(1'h0, 2200);
    chk_flags(1'h0, 1'h0, 1'h0, 1'h0);
    $display("test watchdog prescaler complete");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    tick(20);
    rst <= 1'h0;
    t_por;
    t_pin;
    t_cmp;
    t_wdt_run;
    t_wdt_sleep;
    t_presc;
    tally_and_finish;
  end

  // About 17000 cycles of tests; this span leaves a wide margin
  initial begin
    #400000;
    bad_count++;
    tally_and_finish;
  end
endmodule // sleep_wake_reset_cause_bench
